// ---- logic/stc_dev.sv ----
`timescale 1ns/1ps
`include "stc_params.svh"
module stc_dev (
   input wire logic sys_clk,
   input wire logic arst_n,
   stc_link_if.dev link,
   input wire logic co_side,
   input wire logic [2:0] inst_sel,
   input wire logic demand_valid,
   input wire logic [11:0] demand_rate,
   output logic data_run,
   output logic cfg_ok,
   output logic cfg_err,
   output stc_pkg::stc_state_t link_state,
   output logic [11:0] tx_net_act,
   output logic [5:0] tx_delay_act,
   output logic [11:0] rx_net_act,
   output logic [5:0] rx_delay_act,
   output logic [1:0] err_class,
   output logic [1:0] impulse_guard_floor,
   output logic limit_viol
);

   // ==========================================================
   // Helpers
   // ==========================================================

   // Unpacks a stored block into its fields.
   function automatic stc_pkg::stc_blk_t blk_fields(input logic [63:0] b);
      stc_pkg::stc_blk_t f;
      f.net_max = b[`STC_NET_MAX_LSB +: 12];
      f.net_min = b[`STC_NET_MIN_LSB +: 12];
      f.net_rsv = b[`STC_NET_RSV_LSB +: 12];
      f.delay_max = b[`STC_DELAY_LSB +: 6];
      f.err_class = b[`STC_ERR_LSB +: 2];
      f.impulse_guard_floor = b[`STC_INP_LSB +: 2];
      return f;
   endfunction

   // ==========================================================
   // Parameter store
   // ==========================================================

   logic [63:0] blk_mem [0:`STC_INST_NUM-1];
   logic [7:0] present_reg;
   logic [7:0] present_next;
   logic cfg_err_reg;
   logic cfg_err_next;
   logic accept_ms;
   stc_pkg::stc_state_t state_reg;
   stc_pkg::stc_state_t state_next;
   stc_pkg::stc_blk_t sel_blk;

   // Blocks are taken only before initialization or in L3.
   assign accept_ms = (state_reg == stc_pkg::ST_UNCFG) ||
                      (state_reg == stc_pkg::ST_CFG) ||
                      (state_reg == stc_pkg::ST_L3);
   assign sel_blk = blk_fields(blk_mem[inst_sel]);

   // Tracks which instances were configured and flags reserved codes.
   always_comb
   begin
      present_next = present_reg;
      cfg_err_next = cfg_err_reg;
      if (state_reg == stc_pkg::ST_L3 && link.ms_valid)
      begin
         present_next = 8'h00;
         cfg_err_next = 1'b0;
      end
      if (accept_ms && link.ms_valid)
      begin
         present_next[link.ms_inst] = 1'b1;
      end
      if (accept_ms && link.ms_valid && link.ms_idx == 3'h6 &&
          link.ms_data[`STC_ERR_LSB-8 +: 2] == `STC_ERR_RSVD)
      begin
         cfg_err_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         present_reg <= 8'h00;
         cfg_err_reg <= 1'b0;
      end
      else
      begin
         present_reg <= present_next;
         cfg_err_reg <= cfg_err_next;
      end
   end

   // Octet writes into the block array; octet 0 is the top octet.
   always_ff @(posedge sys_clk)
   begin
      if (accept_ms && link.ms_valid)
      begin
         blk_mem[link.ms_inst][8'(63 - 8 * link.ms_idx) -: 8] <= link.ms_data;
      end
   end

   // ==========================================================
   // Link state
   // ==========================================================

   logic pend_reg;
   logic pend_next;
   logic tx_arm_reg;
   logic tx_arm_next;
   stc_pkg::stc_pm_t tgt_reg;
   stc_pkg::stc_pm_t tgt_next;
   logic tx_switch;
   logic running;

   // The transmit switchover happens on the first transmit octet boundary at or after the confirm.
   assign tx_switch = link.tx_octet && (link.sync_confirm || tx_arm_reg);
   assign running = (state_reg == stc_pkg::ST_L0) || (state_reg == stc_pkg::ST_L2);

   // Steps the configuration and power state machine.
   always_comb
   begin
      state_next = state_reg;
      pend_next = pend_reg;
      tgt_next = tgt_reg;
      case (state_reg)
         stc_pkg::ST_UNCFG, stc_pkg::ST_L3:
         begin
            if (link.ms_valid)
            begin
               state_next = stc_pkg::ST_UNCFG;
            end
            // A message end counts only once a fresh block has moved us out of L3.
            if (link.ms_done && present_next != 8'h00 &&
                state_reg == stc_pkg::ST_UNCFG)
            begin
               state_next = stc_pkg::ST_CFG;
            end
         end
         stc_pkg::ST_CFG:
         begin
            if (link.init_start)
            begin
               state_next = stc_pkg::ST_L0;
            end
         end
         stc_pkg::ST_L0, stc_pkg::ST_L2:
         begin
            if (link.pm_req && link.pm_target == stc_pkg::PM_L3)
            begin
               state_next = stc_pkg::ST_L3;
               pend_next = 1'b0;
            end
            else if (link.pm_req)
            begin
               pend_next = 1'b1;
               tgt_next = link.pm_target;
            end
            else if (pend_reg && tx_switch)
            begin
               pend_next = 1'b0;
               state_next = (tgt_reg == stc_pkg::PM_L2) ? stc_pkg::ST_L2 :
                            stc_pkg::ST_L0;
            end
         end
         default:
         begin
            state_next = stc_pkg::ST_UNCFG;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= stc_pkg::ST_UNCFG;
         pend_reg <= 1'b0;
         tgt_reg <= stc_pkg::PM_L0;
      end
      else
      begin
         state_reg <= state_next;
         pend_reg <= pend_next;
         tgt_reg <= tgt_next;
      end
   end

   // ==========================================================
   // Actual rate and delay
   // ==========================================================

   logic [11:0] sh_net_reg;
   logic [11:0] sh_net_next;
   logic [5:0] sh_delay_reg;
   logic [5:0] sh_delay_next;
   logic rx_arm_reg;
   logic rx_arm_next;
   logic [11:0] tx_net_next;
   logic [5:0] tx_delay_next;
   logic [11:0] rx_net_next;
   logic [5:0] rx_delay_next;
   logic rx_switch;

   assign rx_switch = link.rx_octet && (link.sync_indicate || rx_arm_reg);

   // Stages path values and copies them to each side on its boundary.
   always_comb
   begin
      sh_net_next = sh_net_reg;
      sh_delay_next = sh_delay_reg;
      tx_arm_next = tx_arm_reg;
      rx_arm_next = rx_arm_reg;
      tx_net_next = tx_net_act;
      tx_delay_next = tx_delay_act;
      rx_net_next = rx_net_act;
      rx_delay_next = rx_delay_act;
      if (link.lp_upd)
      begin
         sh_net_next = link.lp_net_act;
         sh_delay_next = link.lp_delay_act;
      end
      if (link.sync_confirm && !link.tx_octet)
      begin
         tx_arm_next = 1'b1;
      end
      if (link.sync_indicate && !link.rx_octet)
      begin
         rx_arm_next = 1'b1;
      end
      if (tx_switch)
      begin
         tx_arm_next = 1'b0;
         tx_net_next = sh_net_reg;
         tx_delay_next = sh_delay_reg;
      end
      if (rx_switch)
      begin
         rx_arm_next = 1'b0;
         rx_net_next = sh_net_reg;
         rx_delay_next = sh_delay_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sh_net_reg <= `STC_ACT_RST_NET;
         sh_delay_reg <= `STC_ACT_RST_DELAY;
         tx_arm_reg <= 1'b0;
         rx_arm_reg <= 1'b0;
         tx_net_act <= `STC_ACT_RST_NET;
         tx_delay_act <= `STC_ACT_RST_DELAY;
         rx_net_act <= `STC_ACT_RST_NET;
         rx_delay_act <= `STC_ACT_RST_DELAY;
      end
      else
      begin
         sh_net_reg <= sh_net_next;
         sh_delay_reg <= sh_delay_next;
         tx_arm_reg <= tx_arm_next;
         rx_arm_reg <= rx_arm_next;
         tx_net_act <= tx_net_next;
         tx_delay_act <= tx_delay_next;
         rx_net_act <= rx_net_next;
         rx_delay_act <= rx_delay_next;
      end
   end

   // ==========================================================
   // Limits, demand watch and outputs
   // ==========================================================

   logic viol_next;
   logic l0_req_next;

   // Checks limits against the transmit actuals and watches upper demand.
   always_comb
   begin
      viol_next = 1'b0;
      l0_req_next = 1'b0;
      if (running && present_reg[inst_sel])
      begin
         viol_next = tx_net_act > sel_blk.net_max;
         if (state_reg == stc_pkg::ST_L0)
         begin
            viol_next = viol_next || (tx_net_act < sel_blk.net_min) ||
                        (tx_net_act < sel_blk.net_rsv) ||
                        (sel_blk.delay_max != 6'h00 &&
                         tx_delay_act > sel_blk.delay_max);
         end
      end
      if (co_side && state_reg == stc_pkg::ST_L2 && !pend_reg && demand_valid &&
          demand_rate > tx_net_act)
      begin
         l0_req_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         limit_viol <= 1'b0;
         link.l0_req <= 1'b0;
         data_run <= 1'b0;
         cfg_ok <= 1'b0;
         cfg_err <= 1'b0;
         link_state <= stc_pkg::ST_UNCFG;
         err_class <= 2'h0;
         impulse_guard_floor <= 2'h0;
      end
      else
      begin
         limit_viol <= viol_next;
         link.l0_req <= l0_req_next;
         data_run <= running;
         cfg_ok <= present_reg[inst_sel];
         cfg_err <= cfg_err_reg;
         link_state <= state_reg;
         err_class <= sel_blk.err_class;
         impulse_guard_floor <= sel_blk.impulse_guard_floor;
      end
   end

endmodule

// ---- common/stc_params.svh ----
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

// Parameter block geometry.
`define STC_BLK_OCTETS 8
`define STC_INST_NUM 8
// Field positions inside a 64-bit block; octet 0 sits in bits 63:56.
`define STC_NET_MAX_LSB 52
`define STC_NET_MIN_LSB 40
`define STC_NET_RSV_LSB 28
`define STC_DELAY_LSB 16
`define STC_ERR_LSB 10
`define STC_INP_LSB 8
// Reset values.
`define STC_ACT_RST_NET 12'h000
`define STC_ACT_RST_DELAY 6'h00
`define STC_BLK_RST 64'h0000_0000_0000_0000
// Reserved error ratio class code.
`define STC_ERR_RSVD 2'h3
// Octet strobe period of the far end in sys_clk cycles.
`define STC_OCT_DIV 4'h8

`endif

// ---- common/stc_pkg.sv ----
package stc_pkg;

   // Link and configuration state of the device end.
   typedef enum logic [2:0] {ST_UNCFG, ST_CFG, ST_L0, ST_L2, ST_L3} stc_state_t;

   // Requested link power state.
   typedef enum logic [1:0] {PM_L0, PM_L2, PM_L3} stc_pm_t;

   // Fields of one parameter block.
   typedef struct packed {
      logic [11:0] net_max;
      logic [11:0] net_min;
      logic [11:0] net_rsv;
      logic [5:0] delay_max;
      logic [1:0] err_class;
      logic [1:0] impulse_guard_floor;
   } stc_blk_t;

endpackage

// ---- common/stc_link_if.sv ----
`timescale 1ns/1ps
// Signals between the device end and the far end on one sys_clk.
interface stc_link_if;
   logic ms_valid;
   logic [2:0] ms_inst;
   logic [2:0] ms_idx;
   logic [7:0] ms_data;
   logic ms_done;
   logic init_start;
   logic lp_upd;
   logic [11:0] lp_net_act;
   logic [5:0] lp_delay_act;
   logic pm_req;
   stc_pkg::stc_pm_t pm_target;
   logic tx_octet;
   logic rx_octet;
   logic sync_confirm;
   logic sync_indicate;
   logic l0_req;

   modport dev (
      input ms_valid, ms_inst, ms_idx, ms_data, ms_done, init_start, lp_upd,
      input lp_net_act, lp_delay_act, pm_req, pm_target, tx_octet, rx_octet,
      input sync_confirm, sync_indicate,
      output l0_req
   );
   modport peer (
      output ms_valid, ms_inst, ms_idx, ms_data, ms_done, init_start, lp_upd,
      output lp_net_act, lp_delay_act, pm_req, pm_target, tx_octet, rx_octet,
      output sync_confirm, sync_indicate,
      input l0_req
   );
endinterface

// ---- logic/stc_peer.sv ----
`timescale 1ns/1ps
`include "stc_params.svh"
module stc_peer (
   input wire logic sys_clk,
   input wire logic arst_n,
   stc_link_if.peer link,
   input wire logic blk_wr,
   input wire logic [2:0] blk_inst,
   input wire logic [63:0] blk_data,
   input wire logic msg_end,
   input wire logic init_go,
   input wire logic lp_upd_in,
   input wire logic [11:0] lp_net_in,
   input wire logic [5:0] lp_delay_in,
   input wire logic pm_go,
   input stc_pkg::stc_pm_t pm_target_in,
   input wire logic sync_go,
   output logic busy,
   output logic l0_wanted
);

   // ==========================================================
   // Mode select sender
   // ==========================================================

   logic [63:0] sh_reg;
   logic [63:0] sh_next;
   logic [2:0] idx_reg;
   logic [2:0] idx_next;
   logic [2:0] inst_reg;
   logic [2:0] inst_next;
   logic busy_next;
   logic sent_reg;
   logic sent_next;
   logic done_next;
   logic init_next;

   // Shifts one block out octet by octet; initialization only after a message.
   always_comb
   begin
      sh_next = sh_reg;
      idx_next = idx_reg;
      inst_next = inst_reg;
      busy_next = busy;
      sent_next = sent_reg;
      done_next = 1'b0;
      init_next = 1'b0;
      if (busy)
      begin
         sh_next = {sh_reg[55:0], 8'h00};
         idx_next = idx_reg + 3'h1;
         busy_next = (idx_reg != 3'h7);
      end
      else if (blk_wr)
      begin
         sh_next = blk_data;
         idx_next = 3'h0;
         inst_next = blk_inst;
         busy_next = 1'b1;
      end
      else if (msg_end)
      begin
         done_next = 1'b1;
         sent_next = 1'b1;
      end
      else if (init_go && sent_reg)
      begin
         init_next = 1'b1;
         sent_next = 1'b0;
      end
      if (pm_go && pm_target_in == stc_pkg::PM_L3)
      begin
         sent_next = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sh_reg <= `STC_BLK_RST;
         idx_reg <= 3'h0;
         inst_reg <= 3'h0;
         busy <= 1'b0;
         sent_reg <= 1'b0;
         link.ms_valid <= 1'b0;
         link.ms_inst <= 3'h0;
         link.ms_idx <= 3'h0;
         link.ms_data <= 8'h00;
         link.ms_done <= 1'b0;
         link.init_start <= 1'b0;
      end
      else
      begin
         sh_reg <= sh_next;
         idx_reg <= idx_next;
         inst_reg <= inst_next;
         busy <= busy_next;
         sent_reg <= sent_next;
         link.ms_valid <= busy;
         link.ms_inst <= inst_reg;
         link.ms_idx <= idx_reg;
         link.ms_data <= sh_reg[63:56];
         link.ms_done <= done_next;
         link.init_start <= init_next;
      end
   end

   // ==========================================================
   // Octet strobes, sync flags, path values and power requests
   // ==========================================================

   logic [3:0] div_reg;
   logic [3:0] div_next;
   logic ind_reg;

   // Divider that marks octet boundaries on both directions.
   always_comb
   begin
      div_next = (div_reg == `STC_OCT_DIV - 4'h1) ? 4'h0 : div_reg + 4'h1;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_reg <= 4'h0;
         ind_reg <= 1'b0;
         link.tx_octet <= 1'b0;
         link.rx_octet <= 1'b0;
         link.sync_confirm <= 1'b0;
         link.sync_indicate <= 1'b0;
         link.lp_upd <= 1'b0;
         link.lp_net_act <= `STC_ACT_RST_NET;
         link.lp_delay_act <= `STC_ACT_RST_DELAY;
         link.pm_req <= 1'b0;
         link.pm_target <= stc_pkg::PM_L0;
         l0_wanted <= 1'b0;
      end
      else
      begin
         div_reg <= div_next;
         link.tx_octet <= (div_reg == 4'h0);
         link.rx_octet <= (div_reg == 4'h1);
         link.sync_confirm <= sync_go;
         ind_reg <= sync_go;
         link.sync_indicate <= ind_reg;
         link.lp_upd <= lp_upd_in;
         if (lp_upd_in)
         begin
            link.lp_net_act <= lp_net_in;
            link.lp_delay_act <= lp_delay_in;
         end
         link.pm_req <= pm_go;
         if (pm_go)
         begin
            link.pm_target <= pm_target_in;
         end
         l0_wanted <= link.l0_req;
      end
   end

endmodule

// ---- bench/stc_link_monitor.sv ----
`timescale 1ns/1ps
// ==========================================================
// Link watcher
// Checks the framing and pulse discipline seen on the link between the two ends.
module stc_link_monitor (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic ms_valid,
   input wire logic [2:0] ms_inst,
   input wire logic [2:0] ms_idx,
   input wire logic ms_done,
   input wire logic init_start,
   input wire logic pm_req,
   input wire logic tx_octet,
   input wire logic rx_octet,
   input wire logic sync_confirm,
   input wire logic sync_indicate,
   input wire logic l0_req
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   // ==========================================================
   // Sequences
   // A parameter block is eight octets back to back, then a gap.
   sequence s_block;
      ms_idx == 3'h0 ##1 ms_valid [*7] ##1 !ms_valid;
   endsequence
   // The receive-side flag follows the transmit-side flag by one cycle.
   sequence s_sync_pair;
      sync_confirm ##1 (sync_indicate && !sync_confirm);
   endsequence

   // ==========================================================
   // Properties
   // Octet indices count up by one within a block.
   property p_ms_seq;
      ms_valid && ms_idx != 3'h7 |=> ms_valid && ms_idx == $past(ms_idx) + 3'h1;
   endproperty
   // All octets of a block belong to one instance.
   property p_ms_inst;
      ms_valid && ms_idx != 3'h7 |=> $stable(ms_inst);
   endproperty
   // A block starts at octet zero and carries exactly eight octets.
   property p_ms_whole;
      $rose(ms_valid) |-> s_block;
   endproperty
   // The end of the message never overlaps octets or the start of initialization.
   property p_done_gap;
      ms_done |-> !ms_valid && !init_start;
   endproperty
   // Initialization start is a single-cycle pulse.
   property p_init_pulse;
      init_start |=> !init_start;
   endproperty
   // Sync flags come as a confirm then an indicate.
   property p_sync;
      sync_confirm |-> s_sync_pair;
   endproperty
   // Octet boundaries recur every eight cycles.
   property p_octet_period;
      tx_octet |=> !tx_octet [*7] ##1 tx_octet;
   endproperty
   // The receive boundary trails the transmit boundary by one cycle.
   property p_rx_follow;
      tx_octet |=> rx_octet;
   endproperty
   // A power change request is a single-cycle pulse.
   property p_pm_pulse;
      pm_req |=> !pm_req;
   endproperty

   a_ms_seq: assert property (p_ms_seq)
      else $error("Octet index skipped within a block.");
   a_ms_inst: assert property (p_ms_inst)
      else $error("Instance changed within a block.");
   a_ms_whole: assert property (p_ms_whole)
      else $error("Block did not carry eight octets.");
   a_done_gap: assert property (p_done_gap)
      else $error("Message end overlapped octets or initialization.");
   a_init_pulse: assert property (p_init_pulse)
      else $error("Initialization start held too long.");
   a_sync: assert property (p_sync)
      else $error("Sync indicate did not follow confirm.");
   a_octet_period: assert property (p_octet_period)
      else $error("Octet boundary period wrong.");
   a_rx_follow: assert property (p_rx_follow)
      else $error("Receive boundary did not trail transmit boundary.");
   a_pm_pulse: assert property (p_pm_pulse)
      else $error("Power request held too long.");

   // Shows that the central side asked to return to full rate.
   c_l0_req: cover property (l0_req);
endmodule

// ---- bench/stc_tc_config_power_ctrl_tb.sv ----
`timescale 1ns/1ps
// ==========================================================
// Bench for both ends joined over the link
module stc_tc_config_power_ctrl_tb;
   logic sys_clk, arst_n, co_side, demand_valid, blk_wr, msg_end, init_go;
   logic lp_upd_in, pm_go, sync_go, data_run, cfg_ok, cfg_err, limit_viol, busy, l0_wanted, seen;
   logic [2:0] inst_sel, blk_inst, inst;
   logic [11:0] demand_rate, lp_net_in, tx_net_act, rx_net_act, exp_net;
   logic [5:0] lp_delay_in, tx_delay_act, rx_delay_act, exp_dly;
   logic [63:0] blk_data;
   logic [1:0] err_class, impulse_guard_floor;
   stc_pkg::stc_pm_t pm_target_in;
   stc_pkg::stc_state_t link_state;
   stc_pkg::stc_blk_t b;
   int miscompares, cmp_count, rnd;

   stc_link_if link ();

   stc_dev u_stc_dev (.sys_clk(sys_clk), .arst_n(arst_n), .link(link), .co_side(co_side),
      .inst_sel(inst_sel), .demand_valid(demand_valid), .demand_rate(demand_rate),
      .data_run(data_run), .cfg_ok(cfg_ok), .cfg_err(cfg_err), .link_state(link_state),
      .tx_net_act(tx_net_act), .tx_delay_act(tx_delay_act), .rx_net_act(rx_net_act),
      .rx_delay_act(rx_delay_act), .err_class(err_class),
      .impulse_guard_floor(impulse_guard_floor), .limit_viol(limit_viol));

   stc_peer u_stc_peer (.sys_clk(sys_clk), .arst_n(arst_n), .link(link), .blk_wr(blk_wr),
      .blk_inst(blk_inst), .blk_data(blk_data), .msg_end(msg_end), .init_go(init_go),
      .lp_upd_in(lp_upd_in), .lp_net_in(lp_net_in), .lp_delay_in(lp_delay_in),
      .pm_go(pm_go), .pm_target_in(pm_target_in), .sync_go(sync_go), .busy(busy),
      .l0_wanted(l0_wanted));

   stc_link_monitor u_stc_link_monitor (.sys_clk(sys_clk), .arst_n(arst_n),
      .ms_valid(link.ms_valid), .ms_inst(link.ms_inst), .ms_idx(link.ms_idx),
      .ms_done(link.ms_done), .init_start(link.init_start), .pm_req(link.pm_req),
      .tx_octet(link.tx_octet), .rx_octet(link.rx_octet), .sync_confirm(link.sync_confirm),
      .sync_indicate(link.sync_indicate), .l0_req(link.l0_req));

   // Free-running 125 MHz clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // Helpers
   // Moves to a later falling edge, where inputs change.
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // Compares one observed value with its expectation.
   task automatic check(input logic [63:0] got, input logic [63:0] want);
      cmp_count++;
      if (got !== want)
      begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, want);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic conclude;
      if (miscompares == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Works out whether the active values break the limits of the current block.
   function automatic logic viol(input logic in_l2);
      return (exp_net > b.net_max) || (!in_l2 && (exp_net < b.net_min ||
         exp_net < b.net_rsv || (b.delay_max != 6'h00 && exp_dly > b.delay_max)));
   endfunction

   // Requests a power state change; only an L3 request reaches the state output before the task returns.
   task automatic pm(input stc_pkg::stc_pm_t t);
      pm_target_in = t;
      pm_go = 1'b1;
      tick(1);
      pm_go = 1'b0;
      tick(3);
   endtask

   // Raises the sync flags and waits past the next octet boundary of both sides.
   task automatic sync;
      sync_go = 1'b1;
      tick(1);
      sync_go = 1'b0;
      tick(14);
   endtask

   // Sends block b for one instance, ends the message and starts initialization.
   task automatic configure(input logic [2:0] which);
      blk_inst = which;
      blk_data = {b.net_max, b.net_min, b.net_rsv, 6'h00, b.delay_max, 4'h0, b.err_class,
         b.impulse_guard_floor, 8'h00};
      blk_wr = 1'b1;
      tick(1);
      blk_wr = 1'b0;
      tick(2);
      for (int i = 0; i < 20 && busy !== 1'b0; i++) tick(1);
      msg_end = 1'b1;
      tick(1);
      msg_end = 1'b0;
      tick(3);
      init_go = 1'b1;
      tick(1);
      init_go = 1'b0;
      tick(5);
   endtask

   // ==========================================================
   // Main sequence: each round configures, updates actuals, visits L2, L0 and L3.
   initial
   begin
      {arst_n, co_side, demand_valid, blk_wr, msg_end, init_go, lp_upd_in, pm_go, sync_go} = '0;
      {inst_sel, blk_inst, demand_rate, lp_net_in, lp_delay_in, blk_data} = '0;
      pm_target_in = stc_pkg::PM_L0;
      {miscompares, cmp_count, exp_net, exp_dly} = '0;
      rnd = $urandom(44);
      repeat (2) @(posedge sys_clk);
      tick(1);
      arst_n = 1'b1;
      for (int r = 0; r < 6; r++)
      begin
         b.net_max = 12'($urandom);
         b.net_min = 12'($urandom);
         b.net_rsv = 12'($urandom);
         b.delay_max = (r == 1) ? 6'h00 : 6'($urandom);
         b.err_class = (r == 0) ? 2'h3 : 2'(r % 3);
         b.impulse_guard_floor = 2'(r);
         inst = 3'($urandom);
         inst_sel = inst ^ 3'h4;
         configure(inst);
         check(cfg_ok, 1'b0);
         inst_sel = inst;
         tick(2);
         check(link_state, stc_pkg::ST_L0);
         check(data_run, 1'b1);
         check(cfg_ok, 1'b1);
         check(cfg_err, b.err_class == 2'h3);
         check(err_class, b.err_class);
         check(impulse_guard_floor, b.impulse_guard_floor);
         check(tx_net_act, exp_net);
         lp_net_in = 12'($urandom_range(0, 4094));
         lp_delay_in = 6'($urandom);
         lp_upd_in = 1'b1;
         tick(1);
         lp_upd_in = 1'b0;
         tick(3);
         check(tx_net_act, exp_net);
         exp_net = lp_net_in;
         exp_dly = lp_delay_in;
         sync();
         check(tx_net_act, exp_net);
         check(tx_delay_act, exp_dly);
         check(rx_net_act, exp_net);
         check(rx_delay_act, exp_dly);
         check(limit_viol, viol(1'b0));
         pm(stc_pkg::PM_L2);
         check(link_state, stc_pkg::ST_L0);
         sync();
         check(link_state, stc_pkg::ST_L2);
         check(data_run, 1'b1);
         check(err_class, b.err_class);
         check(limit_viol, viol(1'b1));
         co_side = 1'(r % 2);
         demand_rate = exp_net + 12'h001;
         demand_valid = 1'b1;
         seen = 1'b0;
         for (int i = 0; i < 6; i++)
         begin
            tick(1);
            seen = seen | (l0_wanted === 1'b1);
         end
         demand_valid = 1'b0;
         check(seen, co_side);
         tick(3);
         pm(stc_pkg::PM_L0);
         sync();
         check(link_state, stc_pkg::ST_L0);
         check(limit_viol, viol(1'b0));
         pm(stc_pkg::PM_L3);
         check(link_state, stc_pkg::ST_L3);
         check(data_run, 1'b0);
         init_go = 1'b1;
         tick(1);
         init_go = 1'b0;
         tick(4);
         check(link_state, stc_pkg::ST_L3);
         msg_end = 1'b1;
         tick(1);
         msg_end = 1'b0;
         tick(2);
         init_go = 1'b1;
         tick(1);
         init_go = 1'b0;
         tick(4);
         check(link_state, stc_pkg::ST_L3);
      end
      conclude();
   end

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      conclude();
   end
endmodule
